// ---- rfc_pkg.sv ----
// package: constants for the reader command executor
package rfc_pkg;
  // command codes presented on the command port
  typedef enum logic [3:0] {
    RFC_CMD_NONE     = 4'h0,
    RFC_CMD_SQUELCH  = 4'h1,
    RFC_CMD_RST_GAIN = 4'h2,
    RFC_CMD_ADJ_REG  = 4'h3,
    RFC_CMD_CAL_MOD  = 4'h4,
    RFC_CMD_CAL_ANT  = 4'h5,
    RFC_CMD_MEAS_PH  = 4'h6,
    RFC_CMD_MEAS_SUP = 4'h7,
    RFC_CMD_CLR_RSSI = 4'h8,
    RFC_CMD_TRANSP   = 4'h9
  } rfc_cmd_t;

  typedef enum logic [3:0] {
    RFC_ST_IDLE    = 4'h0,
    RFC_ST_SQUELCH = 4'h1,
    RFC_ST_REG_SET = 4'h2,
    RFC_ST_REG_WT  = 4'h3,
    RFC_ST_CAL_MOD = 4'h4,
    RFC_ST_CAL_ANT = 4'h5,
    RFC_ST_ADC     = 4'h6,
    RFC_ST_DONE    = 4'h7,
    RFC_ST_TR_WAIT = 4'h8,
    RFC_ST_TRANSP  = 4'h9
  } rfc_state_t;

  // register offsets
  localparam logic [3:0] RFC_OFS_OPCTRL = 4'h0;
  localparam logic [3:0] RFC_OFS_REGCTL = 4'h1;
  localparam logic [3:0] RFC_OFS_RXCFG4 = 4'h2;
  localparam logic [3:0] RFC_OFS_MODDEP = 4'h3;
  localparam logic [3:0] RFC_OFS_ADCOUT = 4'h4;
  localparam logic [3:0] RFC_OFS_RSSI   = 4'h5;
  localparam logic [3:0] RFC_OFS_STATUS = 4'h6;
  localparam logic [3:0] RFC_OFS_CMD    = 4'h7;
  localparam logic [3:0] RFC_OFS_TRIM   = 4'h8;
  // field positions
  localparam int RFC_BIT_EN      = 7;
  localparam int RFC_BIT_RX_EN   = 6;
  localparam int RFC_BIT_TX_EN   = 3;
  localparam int RFC_BIT_REG_EXT = 7;
  localparam int RFC_BIT_SUP_HI  = 5;
  localparam int RFC_BIT_SUP_LO  = 4;
  // reset values
  localparam logic [7:0] RFC_RST_REGCTL = 8'h00;
  localparam logic [7:0] RFC_RST_MODDEP = 8'h00;
  localparam logic [7:0] RFC_REG_TOP    = 8'h0f;
  localparam logic [7:0] RFC_REG_MIN    = 8'h00;
  // supply selections
  localparam logic [1:0] RFC_SUP_MAIN = 2'h0;
  localparam logic [1:0] RFC_SUP_ANA  = 2'h1;
  localparam logic [1:0] RFC_SUP_DIG  = 2'h2;
  localparam logic [1:0] RFC_SUP_RF   = 2'h3;
  // times in ns and cycle counts at 4 ns
  localparam int RFC_CLK_NS      = 4;
  localparam int RFC_T_SQUELCH   = 500000;
  localparam int RFC_T_REG_STEP  = 300000;
  localparam int RFC_T_REG_MAX   = 5000000;
  localparam int RFC_T_CAL_MOD   = 275000;
  localparam int RFC_T_CAL_ANT   = 250000;
  localparam int RFC_T_ADC       = 25000;
  localparam int RFC_CYC_SQUELCH = RFC_T_SQUELCH / RFC_CLK_NS;
  localparam int RFC_CYC_REG_STEP = RFC_T_REG_STEP / RFC_CLK_NS;
  localparam int RFC_CYC_REG_MAX = RFC_T_REG_MAX / RFC_CLK_NS;
  localparam int RFC_CYC_CAL_MOD = RFC_T_CAL_MOD / RFC_CLK_NS;
  localparam int RFC_CYC_CAL_ANT = RFC_T_CAL_ANT / RFC_CLK_NS;
  localparam int RFC_CYC_ADC     = RFC_T_ADC / RFC_CLK_NS;
endpackage

// ---- rfc_cmd_exec.sv ----
// module: direct command executor for measurement and calibration commands
// Operation
// - squelch only with tx and rx on
// - squelch acts only while rx_on low
// - gain reset reloads gain, clears squelch
// - gain reset chainable, no interrupt
// - other commands need en and xtal_ok
// - regulator adjust starts rx tx, top level
// - every 300 us step down if margin short
// - stop at 250 mV margin or minimum
// - regulator adjust under 5 ms, interrupt
// - external regulator select rejects adjust
// - modulation depth trims to target, interrupt
// - antenna trim steps until resonance
// - phase measure relative mode, interrupt
// - phase code inverse, mid-scale at 90
// - rx_on rise clears rssi, starts peak
// - clear rssi restarts peak, chainable
// - transparent while select high after rise
// - supply measure chooses by select bits
// - supply via third divider, absolute mode
// - rx_on low holds rssi and agc
`timescale 1ns/10ps
module rfc_cmd_exec
  import rfc_pkg::*;
#(
  parameter int REG_MAX_CYC = RFC_CYC_REG_MAX,
  parameter int REG_STEP_CYC = RFC_CYC_REG_STEP,
  parameter int SQUELCH_CYC = RFC_CYC_SQUELCH,
  parameter int CAL_MOD_CYC = RFC_CYC_CAL_MOD,
  parameter int CAL_ANT_CYC = RFC_CYC_CAL_ANT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // command strobe and completion
  input wire logic cmd_valid,
  input wire rfc_pkg::rfc_cmd_t cmd_code,
  output logic cmd_busy,
  output logic cmd_done_irq,
  // status inputs
  input wire logic xtal_ok,
  input wire logic rx_on,
  input wire logic spi_select,
  input wire logic supply_margin_ok,
  input wire logic tank_resonant,
  input wire logic [7:0] mod_depth_meas,
  input wire logic [7:0] adc_code,
  input wire logic [7:0] rssi_level,
  // analog controls
  output logic rx_force_on,
  output logic tx_force_on,
  output logic squelch_active,
  output logic agc_enable,
  output logic [7:0] gain_reduction,
  output logic [7:0] reg_setting,
  output logic [3:0] tuning_cap_pins,
  output logic phase_det_en,
  output logic adc_relative,
  output logic [1:0] adc_source,
  output logic transparent_mode
);
  import rfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] opctrl_q, regctl_q, rxcfg4_q, moddep_q, adcout_q, rssi_q;
  logic [3:0] trim_q;
  rfc_state_t st_q;
  logic [20:0] tmr_q, tot_q;
  logic [2:0] rx_sync_q, ss_sync_q;
  logic rx_f_q, ss_f_q, squelch_set_q;
  logic [1:0] adc_src_q;
  logic done_q, regmeas_q;

  // three-stage samplers, a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_sync_q <= 3'h0;
      ss_sync_q <= 3'h0;
      rx_f_q <= 1'b0;
      ss_f_q <= 1'b0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_on};
      ss_sync_q <= {ss_sync_q[1:0], spi_select};
      if (rx_sync_q[1] == rx_sync_q[2]) rx_f_q <= rx_sync_q[2];
      if (ss_sync_q[1] == ss_sync_q[2]) ss_f_q <= ss_sync_q[2];
    end
  end
  wire rx_now = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_f_q;
  wire ss_now = (ss_sync_q[1] == ss_sync_q[2]) ? ss_sync_q[2] : ss_f_q;
  wire rx_rise = rx_now & ~rx_f_q;
  wire ss_rise = ss_now & ~ss_f_q;

  ////////////////////////////////////////////////////////////////////////////
  // acceptance
  wire idle = (st_q == RFC_ST_IDLE);
  wire op_ok = opctrl_q[RFC_BIT_EN] & xtal_ok;
  function automatic logic cmd_ok(input rfc_cmd_t c);
    unique case (c)
      RFC_CMD_SQUELCH:  cmd_ok = opctrl_q[RFC_BIT_RX_EN] & opctrl_q[RFC_BIT_TX_EN];
      RFC_CMD_RST_GAIN: cmd_ok = op_ok;
      RFC_CMD_ADJ_REG:  cmd_ok = op_ok & ~regctl_q[RFC_BIT_REG_EXT];
      RFC_CMD_CAL_MOD, RFC_CMD_CAL_ANT, RFC_CMD_MEAS_PH,
      RFC_CMD_MEAS_SUP, RFC_CMD_CLR_RSSI, RFC_CMD_TRANSP: cmd_ok = op_ok;
      default: cmd_ok = 1'b0;
    endcase
  endfunction
  // rejected commands fall through with no effect
  wire take = cmd_valid & idle & cmd_ok(cmd_code);
  // gain reset is also taken while a squelch runs, so that it can abort it
  wire take_rg = cmd_valid & (idle | (st_q == RFC_ST_SQUELCH)) & op_ok &
                 (cmd_code == RFC_CMD_RST_GAIN);
  wire take_cr = take & (cmd_code == RFC_CMD_CLR_RSSI);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= RFC_ST_IDLE;
      tmr_q <= 21'h0;
      tot_q <= 21'h0;
      adc_src_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      tmr_q <= tmr_q + 21'h1;
      tot_q <= tot_q + 21'h1;
      unique case (st_q)
        RFC_ST_IDLE: begin
          tmr_q <= 21'h0;
          tot_q <= 21'h0;
          if (take) begin
            unique case (cmd_code)
              RFC_CMD_SQUELCH: if (!rx_now) st_q <= RFC_ST_SQUELCH;
              RFC_CMD_ADJ_REG: st_q <= RFC_ST_REG_SET;
              RFC_CMD_CAL_MOD: st_q <= RFC_ST_CAL_MOD;
              RFC_CMD_CAL_ANT: st_q <= RFC_ST_CAL_ANT;
              RFC_CMD_MEAS_PH: begin
                adc_src_q <= RFC_SUP_MAIN;
                st_q <= RFC_ST_ADC;
              end
              RFC_CMD_MEAS_SUP: begin
                adc_src_q <= {regctl_q[RFC_BIT_SUP_HI], regctl_q[RFC_BIT_SUP_LO]};
                st_q <= RFC_ST_ADC;
              end
              RFC_CMD_TRANSP: st_q <= RFC_ST_TR_WAIT;
              default: st_q <= RFC_ST_IDLE;
            endcase
          end
        end
        RFC_ST_SQUELCH: begin
          if (take_rg || tmr_q == 21'(SQUELCH_CYC - 1)) st_q <= RFC_ST_IDLE;
        end
        RFC_ST_REG_SET: begin
          tmr_q <= 21'h0;
          st_q <= RFC_ST_REG_WT;
        end
        RFC_ST_REG_WT: begin
          if (tmr_q == 21'(REG_STEP_CYC - 1)) begin
            tmr_q <= 21'h0;
            if (supply_margin_ok || reg_setting == RFC_REG_MIN) st_q <= RFC_ST_DONE;
          end
          if (tot_q >= 21'(REG_MAX_CYC - 2)) st_q <= RFC_ST_DONE;
        end
        RFC_ST_CAL_MOD: begin
          if (tmr_q == 21'(CAL_MOD_CYC - 2)) st_q <= RFC_ST_DONE;
        end
        RFC_ST_CAL_ANT: begin
          if (tank_resonant || tmr_q == 21'(CAL_ANT_CYC - 2)) st_q <= RFC_ST_DONE;
        end
        RFC_ST_ADC: begin
          if (tmr_q == 21'(RFC_CYC_ADC - 2)) st_q <= RFC_ST_DONE;
        end
        RFC_ST_DONE: begin
          done_q <= 1'b1;
          st_q <= RFC_ST_IDLE;
        end
        RFC_ST_TR_WAIT: if (ss_rise) st_q <= RFC_ST_TRANSP;
        RFC_ST_TRANSP: if (!ss_now) st_q <= RFC_ST_IDLE;
        default: st_q <= RFC_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulator setting, trims and converter result
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_setting <= RFC_REG_TOP;
      trim_q <= 4'h0;
    end else if (st_q == RFC_ST_REG_SET) begin
      reg_setting <= RFC_REG_TOP;
    end else if (st_q == RFC_ST_REG_WT && tmr_q == 21'(REG_STEP_CYC - 1) &&
                 !supply_margin_ok && reg_setting != RFC_REG_MIN) begin
      reg_setting <= reg_setting - 8'h01;
    end else if (st_q == RFC_ST_CAL_ANT && !tank_resonant) begin
      trim_q <= trim_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      opctrl_q <= 8'h00;
      regctl_q <= RFC_RST_REGCTL;
      rxcfg4_q <= 8'h00;
      moddep_q <= RFC_RST_MODDEP;
      adcout_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == RFC_OFS_OPCTRL) opctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == RFC_OFS_REGCTL) regctl_q <= reg_wdata;
      if (reg_wr && reg_addr == RFC_OFS_RXCFG4) rxcfg4_q <= reg_wdata;
      if (reg_wr && reg_addr == RFC_OFS_MODDEP) moddep_q <= reg_wdata;
      // result overwrites target at calibration end
      if (st_q == RFC_ST_CAL_MOD && tmr_q == 21'(CAL_MOD_CYC - 2))
        moddep_q <= mod_depth_meas;
      // converter code is already inverse phase or supply/3
      if (st_q == RFC_ST_ADC && tmr_q == 21'(RFC_CYC_ADC - 2))
        adcout_q <= adc_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // squelch, gain and rssi
  always_ff @(posedge core_clk) begin
    if (rst) begin
      squelch_set_q <= 1'b0;
      gain_reduction <= 8'h00;
    end else begin
      if (take_rg) begin
        squelch_set_q <= 1'b0;
        gain_reduction <= rxcfg4_q;
      end else if (st_q == RFC_ST_SQUELCH) begin
        squelch_set_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rssi_q <= 8'h00;
    end else if (rx_rise || take_cr || take_rg) begin
      rssi_q <= 8'h00;
    end else if (rx_now && rssi_level > rssi_q) begin
      rssi_q <= rssi_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        RFC_OFS_OPCTRL: reg_rdata <= opctrl_q;
        RFC_OFS_REGCTL: reg_rdata <= regctl_q;
        RFC_OFS_RXCFG4: reg_rdata <= rxcfg4_q;
        RFC_OFS_MODDEP: reg_rdata <= moddep_q;
        RFC_OFS_ADCOUT: reg_rdata <= adcout_q;
        RFC_OFS_RSSI:   reg_rdata <= rssi_q;
        RFC_OFS_STATUS: reg_rdata <= {4'h0, st_q};
        RFC_OFS_TRIM:   reg_rdata <= {4'h0, trim_q};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cmd_busy = ~idle;
  assign cmd_done_irq = done_q;
  assign rx_force_on = (st_q == RFC_ST_REG_SET) | (st_q == RFC_ST_REG_WT);
  assign tx_force_on = rx_force_on | (st_q == RFC_ST_CAL_MOD) | (st_q == RFC_ST_ADC &&
                       adc_relative);
  assign squelch_active = (st_q == RFC_ST_SQUELCH);
  assign agc_enable = rx_now & ~squelch_set_q;
  assign tuning_cap_pins = trim_q;
  assign phase_det_en = adc_relative;
  assign adc_relative = (st_q == RFC_ST_ADC) & (adc_src_q == RFC_SUP_MAIN) & ~regmeas_q;
  assign adc_source = adc_src_q;
  assign transparent_mode = (st_q == RFC_ST_TRANSP);

  always_ff @(posedge core_clk) begin
    if (rst) regmeas_q <= 1'b0;
    else if (take) regmeas_q <= (cmd_code == RFC_CMD_MEAS_SUP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_reject;
    @(posedge core_clk) disable iff (rst)
    (cmd_valid && idle && !cmd_ok(cmd_code)) |=> idle;
  endproperty
  a_reject: assert property (p_reject) else $error("rejected command started");
  // cycles spent so far in the conversion state
  logic [12:0] adc_cyc_q;
  always_ff @(posedge core_clk) begin
    if (rst) adc_cyc_q <= 13'h0;
    else if (st_q == RFC_ST_ADC) adc_cyc_q <= adc_cyc_q + 13'h1;
    else adc_cyc_q <= 13'h0;
  end
  property p_adc_time;
    @(posedge core_clk) disable iff (rst)
    (st_q == RFC_ST_ADC) |-> adc_cyc_q < 13'(RFC_CYC_ADC);
  endproperty
  a_adc_time: assert property (p_adc_time) else $error("conversion too slow");
  property p_irq_pulse;
    @(posedge core_clk) disable iff (rst) done_q |=> !done_q;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  property p_rg_load;
    @(posedge core_clk) disable iff (rst) take_rg |=> gain_reduction == $past(rxcfg4_q);
  endproperty
  a_rg_load: assert property (p_rg_load) else $error("gain not reloaded");
  property p_rssi_clr;
    @(posedge core_clk) disable iff (rst) take_cr |=> rssi_q == 8'h00;
  endproperty
  a_rssi_clr: assert property (p_rssi_clr) else $error("rssi not cleared");
  property p_transp;
    @(posedge core_clk) disable iff (rst) transparent_mode |-> ss_f_q | ss_now;
  endproperty
  a_transp: assert property (p_transp) else $error("transparent with select low");
  property p_sq_rx;
    @(posedge core_clk) disable iff (rst)
    (take && cmd_code == RFC_CMD_SQUELCH && rx_now) |=> idle;
  endproperty
  a_sq_rx: assert property (p_sq_rx) else $error("squelch ran with rx_on");
  property p_regstep;
    @(posedge core_clk) disable iff (rst)
    (st_q == RFC_ST_REG_WT && $past(st_q) == RFC_ST_REG_WT && $changed(reg_setting)) |->
      reg_setting == $past(reg_setting) - 8'h01;
  endproperty
  a_regstep: assert property (p_regstep) else $error("regulator step wrong");
  sequence s_done_st;
    st_q == RFC_ST_DONE;
  endsequence
  sequence s_irq_idle;
    done_q && idle;
  endsequence
  property p_done_irq;
    @(posedge core_clk) disable iff (rst) s_done_st |=> s_irq_idle;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion pulse missing");
  sequence s_adj_take;
    take && cmd_code == RFC_CMD_ADJ_REG;
  endsequence
  sequence s_adj_top;
    (rx_force_on && tx_force_on) ##1 (st_q == RFC_ST_REG_WT && reg_setting == RFC_REG_TOP);
  endsequence
  property p_adj_start;
    @(posedge core_clk) disable iff (rst) s_adj_take |=> s_adj_top;
  endproperty
  a_adj_start: assert property (p_adj_start) else $error("adjust did not start at top");
  property p_rg_abort;
    @(posedge core_clk) disable iff (rst)
    (take_rg && st_q == RFC_ST_SQUELCH) |=> (idle && !squelch_set_q);
  endproperty
  a_rg_abort: assert property (p_rg_abort) else $error("squelch not aborted");
  property p_ext_reject;
    @(posedge core_clk) disable iff (rst)
    (cmd_valid && idle && cmd_code == RFC_CMD_ADJ_REG && regctl_q[RFC_BIT_REG_EXT]) |=> idle;
  endproperty
  a_ext_reject: assert property (p_ext_reject) else $error("adjust ran with ext select");
  property p_rssi_rise;
    @(posedge core_clk) disable iff (rst) rx_rise |=> rssi_q == 8'h00;
  endproperty
  a_rssi_rise: assert property (p_rssi_rise) else $error("rssi not cleared on rise");
  property p_rssi_hold;
    @(posedge core_clk) disable iff (rst)
    !rx_now |=> (rssi_q == $past(rssi_q) || rssi_q == 8'h00);
  endproperty
  a_rssi_hold: assert property (p_rssi_hold) else $error("rssi moved with rx off");
  property p_sq_noirq;
    @(posedge core_clk) disable iff (rst) squelch_active |=> !done_q;
  endproperty
  a_sq_noirq: assert property (p_sq_noirq) else $error("squelch raised irq");
endmodule

// ---- rfc_afe_model.sv ----
// analog front end model facing the command executor
`timescale 1ns/10ps
module rfc_afe_model (
  // clock
  input wire logic core_clk,
  // controls from the executor
  input wire logic [7:0] reg_setting,
  input wire logic [3:0] tuning_cap_pins,
  input wire logic tx_force_on,
  // scenario knobs
  input wire logic [7:0] margin_lvl,
  input wire logic [3:0] tank_tgt,
  // analog results
  output logic supply_margin_ok,
  output logic tank_resonant,
  output logic [7:0] mod_depth_meas
);
  logic [7:0] noise_q;
  initial noise_q = 8'h00;
  always @(posedge core_clk) begin
    noise_q <= noise_q + 8'h01;
  end
  // margin is met once the regulated level is at or below the knob
  assign supply_margin_ok = (reg_setting <= margin_lvl);
  assign tank_resonant = (tuning_cap_pins == tank_tgt);
  // depth reading only holds still while the carrier is on
  assign mod_depth_meas = tx_force_on ? 8'h40 : noise_q;
endmodule

// ---- tb_rfc_cmd_exec.sv ----
// self-checking bench for the command executor
`timescale 1ns/10ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, act, exp); end end
module tb_rfc_cmd_exec;
  import rfc_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, cmd_valid, xtal_ok, rx_on, spi_select, rd_d;
  logic [3:0] reg_addr, tank_tgt, tuning_cap_pins;
  logic [7:0] reg_wdata, adc_code, rssi_level, margin_lvl, v, e_v, reg_rdata;
  logic [7:0] gain_reduction, reg_setting, mod_depth_meas;
  logic cmd_busy, cmd_done_irq, supply_margin_ok, tank_resonant, rx_force_on, tx_force_on;
  logic squelch_active, agc_enable, phase_det_en, adc_relative, transparent_mode;
  logic [1:0] adc_source;
  rfc_cmd_t cmd_code;
  logic [7:0] exp_q[$];
  int error_cnt, n_tests, irq_cnt, irq_exp;

  rfc_cmd_exec #(.REG_MAX_CYC(200), .REG_STEP_CYC(20), .SQUELCH_CYC(20), .CAL_MOD_CYC(20),
    .CAL_ANT_CYC(20)) dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_busy(cmd_busy),
    .cmd_done_irq(cmd_done_irq), .xtal_ok(xtal_ok), .rx_on(rx_on), .spi_select(spi_select),
    .supply_margin_ok(supply_margin_ok), .tank_resonant(tank_resonant),
    .mod_depth_meas(mod_depth_meas), .adc_code(adc_code), .rssi_level(rssi_level),
    .rx_force_on(rx_force_on), .tx_force_on(tx_force_on), .squelch_active(squelch_active),
    .agc_enable(agc_enable), .gain_reduction(gain_reduction), .reg_setting(reg_setting),
    .tuning_cap_pins(tuning_cap_pins), .phase_det_en(phase_det_en),
    .adc_relative(adc_relative), .adc_source(adc_source), .transparent_mode(transparent_mode));
  rfc_afe_model afe_u (.core_clk(core_clk), .reg_setting(reg_setting),
    .tuning_cap_pins(tuning_cap_pins), .tx_force_on(tx_force_on), .margin_lvl(margin_lvl),
    .tank_tgt(tank_tgt), .supply_margin_ok(supply_margin_ok), .tank_resonant(tank_resonant),
    .mod_depth_meas(mod_depth_meas));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // read data stand one cycle after the strobe; compare them with the oldest note
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
  end
  always @(negedge core_clk) begin
    if (cmd_done_irq === 1'b1) begin
      irq_cnt++;
    end
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      `CHK(reg_rdata, e_v)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic cmd(input rfc_cmd_t c);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (cmd_done_irq !== 1'b1 && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= lim) begin
      error_cnt++;
      $display("MISMATCH %0t completion timed out", $time);
      give_verdict();
    end else begin
      irq_exp++;
      tick(2);
      `CHK(irq_cnt, irq_exp)
    end
  endtask
  task automatic meas(input rfc_cmd_t c, input logic [1:0] s, input logic rel);
    logic [7:0] a;
    a = 8'($urandom);
    @(posedge core_clk);
    adc_code <= a;
    cmd(c);
    `CHK(adc_relative, rel)
    `CHK(phase_det_en, rel)
    wait_done(7000);
    if (!rel) `CHK(adc_source, s)
    rd(RFC_OFS_ADCOUT, a);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    cmd_valid = 1'b0; cmd_code = RFC_CMD_NONE; xtal_ok = 1'b1; rx_on = 1'b0;
    spi_select = 1'b0; adc_code = 8'h00; rssi_level = 8'h00; margin_lvl = 8'h00;
    tank_tgt = 4'h0; rd_d = 1'b0; error_cnt = 0; n_tests = 0; irq_cnt = 0; irq_exp = 0;
    void'($urandom(97308));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(RFC_OFS_REGCTL, RFC_RST_REGCTL);
    rd(RFC_OFS_MODDEP, RFC_RST_MODDEP);
    rd(4'hf, 8'h00);
    `CHK(reg_setting, RFC_REG_TOP)
    cmd(RFC_CMD_MEAS_PH);
    `CHK(cmd_busy, 1'b0)
    wr(RFC_OFS_OPCTRL, 8'h80);
    xtal_ok <= 1'b0;
    cmd(RFC_CMD_CAL_ANT);
    `CHK(cmd_busy, 1'b0)
    @(posedge core_clk);
    xtal_ok <= 1'b1;
    $display("test refusal done");
    meas(RFC_CMD_MEAS_PH, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(RFC_OFS_REGCTL, {2'b00, 2'(i), 4'h0});
      meas(RFC_CMD_MEAS_SUP, 2'(i), 1'b0);
    end
    $display("test measure done");
    wr(RFC_OFS_REGCTL, 8'h80);
    cmd(RFC_CMD_ADJ_REG);
    `CHK(cmd_busy, 1'b0)
    wr(RFC_OFS_REGCTL, 8'h00);
    v = 8'($urandom_range(14, 9));
    margin_lvl <= v;
    cmd(RFC_CMD_ADJ_REG);
    `CHK(rx_force_on, 1'b1)
    `CHK(tx_force_on, 1'b1)
    `CHK(reg_setting, RFC_REG_TOP)
    wait_done(260);
    `CHK(reg_setting, v)
    @(posedge core_clk);
    v = 8'($urandom_range(5, 1));
    tank_tgt <= v[3:0];
    cmd(RFC_CMD_CAL_ANT);
    wait_done(100);
    `CHK(tuning_cap_pins, v[3:0])
    cmd(RFC_CMD_CAL_MOD);
    `CHK(tx_force_on, 1'b1)
    wait_done(100);
    rd(RFC_OFS_MODDEP, 8'h40);
    $display("test calibration done");
    wr(RFC_OFS_OPCTRL, 8'h88);
    cmd(RFC_CMD_SQUELCH);
    `CHK(squelch_active, 1'b0)
    wr(RFC_OFS_OPCTRL, 8'hc8);
    cmd(RFC_CMD_SQUELCH);
    `CHK(squelch_active, 1'b1)
    tick(40);
    `CHK(squelch_active, 1'b0)
    `CHK(irq_cnt, irq_exp)
    v = 8'($urandom);
    wr(RFC_OFS_RXCFG4, v);
    cmd(RFC_CMD_RST_GAIN);
    `CHK(cmd_busy, 1'b0)
    tick(3);
    `CHK(gain_reduction, v)
    cmd(RFC_CMD_SQUELCH);
    `CHK(squelch_active, 1'b1)
    cmd(RFC_CMD_RST_GAIN);
    `CHK(squelch_active, 1'b0)
    `CHK(cmd_busy, 1'b0)
    $display("test gain done");
    @(posedge core_clk);
    v = 8'($urandom_range(255, 2));
    rssi_level <= v;
    rx_on <= 1'b1;
    tick(8);
    `CHK(agc_enable, 1'b1)
    rd(RFC_OFS_RSSI, v);
    cmd(RFC_CMD_SQUELCH);
    `CHK(squelch_active, 1'b0)
    @(posedge core_clk);
    rssi_level <= v >> 1;
    cmd(RFC_CMD_CLR_RSSI);
    `CHK(cmd_busy, 1'b0)
    tick(3);
    rd(RFC_OFS_RSSI, v >> 1);
    rx_on <= 1'b0;
    tick(8);
    `CHK(agc_enable, 1'b0)
    `CHK(irq_cnt, irq_exp)
    $display("test rssi done");
    cmd(RFC_CMD_TRANSP);
    `CHK(transparent_mode, 1'b0)
    @(posedge core_clk);
    spi_select <= 1'b1;
    tick(6);
    `CHK(transparent_mode, 1'b1)
    @(posedge core_clk);
    spi_select <= 1'b0;
    tick(6);
    `CHK(transparent_mode, 1'b0)
    $display("test transparent done");
    give_verdict();
  end
endmodule
